//--- rtl/tfl_trajectory_filter_loader.v
`timescale 1ns/10ps
`include "tfl_consts.vh"
module tfl_trajectory_filter_loader #(
   parameter SAMPLE_CLKS = `TFL_SAMPLE_CLKS,
   parameter DRIVE_W = 12
) (
   input wire clk,
   input wire nrst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire trajDone,
   input wire [31:0] actualPos,
   input wire [DRIVE_W-1:0] pidDrive,
   output reg [DRIVE_W-1:0] driveOut,
   output reg [31:0] workAccel,
   output reg [31:0] workVel,
   output reg [31:0] workTarget,
   output reg velMode,
   output reg fwdDir,
   output reg motorOff,
   output reg startPulse,
   output reg smoothStop,
   output reg [15:0] proportionalGain,
   output reg [15:0] integralGain,
   output reg [15:0] derivativeGain,
   output reg [15:0] integrationLimit,
   output reg [7:0] derivCode,
   output wire sampleTick,
   output wire derivTick
);
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_CTLW = 2'b01;
   localparam [1:0] ST_DATA = 2'b10;

   reg [1:0] state_r;
   reg isTraj_r;
   reg [3:0] rem_r;
   reg half_r;
   reg [15:0] hold_r;
   reg [15:0] pendTcw_r;
   reg [2:0] pendLd_r;
   reg [31:0] bufAcc_r, bufVel_r, bufPos_r;
   reg [15:0] bufKp_r, bufKi_r, bufKd_r, bufIl_r;
   reg [7:0] bufIvl_r;
   reg accelLoaded_r, moving_r, cmdErr_r, startPend_r, udfPend_r;
   reg [3:0] busyCnt_r;
   reg [31:0] rdData;
   reg mapped;
   wire [15:0] word;
   wire wordStb;
   wire [1:0] idx;
   wire [3:0] remClr;
   wire busy;
   wire apbSetup, apbDo, wrCmd, wrData, cmdOk, dataOk;

   // ----------------------------------------
   // highest flagged item still to come
   // ----------------------------------------
   function [1:0] topIdx;
      input [3:0] r;
      begin
         topIdx = r[3] ? 2'd3 : r[2] ? 2'd2 : r[1] ? 2'd1 : 2'd0;
      end
   endfunction

   // ----------------------------------------
   // bus decode and write acceptance
   // ----------------------------------------
   assign apbSetup = psel & ~penable;
   assign apbDo = psel & penable & pready;
   assign busy = (busyCnt_r != 4'h0) | startPend_r;
   assign wrCmd = apbDo & pwrite & (paddr == `TFL_OFF_CMD);
   assign wrData = apbDo & pwrite & (paddr == `TFL_OFF_DATA);
   assign cmdOk = wrCmd & ~busy;
   assign dataOk = wrData & ~busy & (state_r != ST_IDLE);
   assign idx = topIdx(rem_r);
   assign remClr = rem_r & ~(4'h1 << idx);

   tfl_word_asm u_asm (
      .clk(clk),
      .nrst(nrst),
      .clear(cmdOk),
      .byteStb(dataOk),
      .byteIn(pwdata[7:0]),
      .wordStb(wordStb),
      .wordOut(word)
   );

   tfl_sample_timer #(
      .SAMPLE_CLKS(SAMPLE_CLKS)
   ) u_timer (
      .clk(clk),
      .nrst(nrst),
      .derivCode(derivCode),
      .sampleTick(sampleTick),
      .derivTick(derivTick)
   );

   // ----------------------------------------
   // read mux
   // ----------------------------------------
   always @* begin
      mapped = 1'b1;
      rdData = 32'h00000000;
      case (paddr)
         `TFL_OFF_CMD, `TFL_OFF_DATA: rdData = 32'h00000000;
         `TFL_OFF_STATUS: begin
            rdData[`TFL_ST_BUSY] = busy;
            rdData[`TFL_ST_CMDERR] = cmdErr_r;
            rdData[`TFL_ST_TDONE] = ~moving_r;
            rdData[`TFL_ST_MOFF] = motorOff;
            rdData[`TFL_ST_ACCLD] = accelLoaded_r;
            rdData[`TFL_ST_UDFP] = udfPend_r;
            rdData[`TFL_ST_FWD] = fwdDir;
            rdData[`TFL_ST_VEL] = velMode;
            rdData[`TFL_ST_MOVING] = moving_r;
         end
         `TFL_OFF_ACC: rdData = workAccel;
         `TFL_OFF_VEL: rdData = workVel;
         `TFL_OFF_POS: rdData = workTarget;
         `TFL_OFF_GAINA: rdData = {proportionalGain, integralGain};
         `TFL_OFF_GAINB: rdData = {derivativeGain, integrationLimit};
         `TFL_OFF_FILTCTL: rdData = {24'h000000, derivCode};
         default: mapped = 1'b0;
      endcase
   end

   // ----------------------------------------
   // apb slave: one access cycle, no wait
   // ----------------------------------------
   // data is captured in setup so prdata is a flop and stable in access
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= apbSetup;
         pslverr <= apbSetup & ~mapped;
         if (apbSetup) begin
            prdata <= pwrite ? 32'h00000000 : rdData;
         end
      end
   end

   // ----------------------------------------
   // busy window after each accepted command or data write
   // ----------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         busyCnt_r <= 4'h0;
      end else if (cmdOk | dataOk) begin
         busyCnt_r <= `TFL_BUSY_CYCLES;
      end else if (busyCnt_r != 4'h0) begin
         busyCnt_r <= busyCnt_r - 4'h1;
      end
   end

   // ----------------------------------------
   // command decoder and primary buffers
   // ----------------------------------------
   // a new command always restarts the sequence; stray data in idle is dropped
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         isTraj_r <= 1'b0;
         rem_r <= 4'h0;
         half_r <= 1'b0;
         hold_r <= `TFL_RST_WORD16;
         pendTcw_r <= `TFL_RST_WORD16;
         pendLd_r <= 3'b000;
         bufAcc_r <= `TFL_RST_WORD32;
         bufVel_r <= `TFL_RST_WORD32;
         bufPos_r <= `TFL_RST_WORD32;
         bufKp_r <= `TFL_RST_WORD16;
         bufKi_r <= `TFL_RST_WORD16;
         bufKd_r <= `TFL_RST_WORD16;
         bufIl_r <= `TFL_RST_WORD16;
         bufIvl_r <= 8'h00;
         accelLoaded_r <= 1'b0;
      end else begin
         if (startPend_r & sampleTick) begin
            pendLd_r <= 3'b000;
            accelLoaded_r <= 1'b0;
            pendTcw_r[`TFL_TCW_SMOOTH:`TFL_TCW_OFF] <= 3'b000;
         end
         if (cmdOk) begin
            half_r <= 1'b0;
            isTraj_r <= (pwdata[7:0] == `TFL_CMD_LOADTRAJ);
            if (pwdata[7:0] == `TFL_CMD_LOADTRAJ || pwdata[7:0] == `TFL_CMD_LOADFILT) begin
               state_r <= ST_CTLW;
            end else begin
               state_r <= ST_IDLE;
            end
         end else if (wordStb && state_r == ST_CTLW) begin
            half_r <= 1'b0;
            if (isTraj_r) begin
               // only defined fields are taken; bits 15:13, 7 and 6 are dropped
               pendTcw_r <= {3'b000, word[12:8], 2'b00, word[5:0]};
               rem_r <= {1'b0, word[`TFL_TCW_ACC_LD], word[`TFL_TCW_VEL_LD], word[`TFL_TCW_POS_LD]};
               state_r <= (word[`TFL_TCW_ACC_LD] | word[`TFL_TCW_VEL_LD] | word[`TFL_TCW_POS_LD]) ? ST_DATA : ST_IDLE;
            end else begin
               bufIvl_r <= word[`TFL_FCW_IVL_HI:`TFL_FCW_IVL_LO];
               rem_r <= word[`TFL_FCW_FLG_HI:0];
               state_r <= (word[`TFL_FCW_FLG_HI:0] != 4'h0) ? ST_DATA : ST_IDLE;
            end
         end else if (wordStb && state_r == ST_DATA) begin
            if (isTraj_r && !half_r) begin
               hold_r <= word;
               half_r <= 1'b1;
            end else begin
               half_r <= 1'b0;
               rem_r <= remClr;
               if (remClr == 4'h0) begin
                  state_r <= ST_IDLE;
               end
               if (isTraj_r) begin
                  pendLd_r[idx] <= 1'b1;
                  case (idx)
                     2'd2: begin
                        bufAcc_r <= {hold_r, word};
                        accelLoaded_r <= 1'b1;
                     end
                     2'd1: bufVel_r <= {hold_r, word};
                     default: bufPos_r <= {hold_r, word};
                  endcase
               end else begin
                  case (idx)
                     2'd3: bufKp_r <= word;
                     2'd2: bufKi_r <= word;
                     2'd1: bufKd_r <= word;
                     default: bufIl_r <= word;
                  endcase
               end
            end
         end
      end
   end

   // ----------------------------------------
   // start and update requests, command error
   // ----------------------------------------
   // request set comes after the boundary clear, so a late set is never lost
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         startPend_r <= 1'b0;
         udfPend_r <= 1'b0;
         cmdErr_r <= 1'b0;
      end else begin
         if (sampleTick) begin
            startPend_r <= 1'b0;
            udfPend_r <= 1'b0;
         end
         if (apbDo && pwrite && paddr == `TFL_OFF_STATUS && pwdata[`TFL_ST_CMDERR]) begin
            cmdErr_r <= 1'b0;
         end
         if (cmdOk && pwdata[7:0] == `TFL_CMD_START) begin
            if (accelLoaded_r && moving_r) begin
               cmdErr_r <= 1'b1;
            end else begin
               startPend_r <= 1'b1;
            end
         end
         if (cmdOk && pwdata[7:0] == `TFL_CMD_UPDFILT) begin
            udfPend_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // working filter set
   // ----------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         proportionalGain <= `TFL_RST_WORD16;
         integralGain <= `TFL_RST_WORD16;
         derivativeGain <= `TFL_RST_WORD16;
         integrationLimit <= `TFL_RST_WORD16;
         derivCode <= 8'h00;
      end else if (udfPend_r & sampleTick) begin
         proportionalGain <= bufKp_r;
         integralGain <= bufKi_r;
         derivativeGain <= bufKd_r;
         integrationLimit <= bufIl_r;
         derivCode <= bufIvl_r;
      end
   end

   // ----------------------------------------
   // working trajectory set and motion state
   // ----------------------------------------
   // relative values add to the working value so queued moves chain
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         workAccel <= `TFL_RST_WORD32;
         workVel <= `TFL_RST_WORD32;
         workTarget <= `TFL_RST_WORD32;
         velMode <= 1'b0;
         fwdDir <= 1'b0;
         motorOff <= `TFL_RST_MOFF;
         moving_r <= 1'b0;
         startPulse <= 1'b0;
         smoothStop <= 1'b0;
      end else begin
         startPulse <= 1'b0;
         smoothStop <= 1'b0;
         if (trajDone) begin
            moving_r <= 1'b0;
         end
         if (startPend_r & sampleTick) begin
            velMode <= pendTcw_r[`TFL_TCW_VEL];
            if (pendTcw_r[`TFL_TCW_VEL]) begin
               fwdDir <= pendTcw_r[`TFL_TCW_FWD];
            end
            if (pendLd_r[2]) begin
               workAccel <= pendTcw_r[`TFL_TCW_ACC_REL] ? workAccel + bufAcc_r : bufAcc_r;
            end
            if (pendLd_r[1]) begin
               workVel <= pendTcw_r[`TFL_TCW_VEL_REL] ? workVel + bufVel_r : bufVel_r;
            end
            if (pendTcw_r[`TFL_TCW_ABRUPT]) begin
               workTarget <= actualPos;
            end else if (pendLd_r[0]) begin
               workTarget <= pendTcw_r[`TFL_TCW_POS_REL] ? workTarget + bufPos_r : bufPos_r;
            end
            motorOff <= pendTcw_r[`TFL_TCW_OFF];
            smoothStop <= pendTcw_r[`TFL_TCW_SMOOTH];
            // a plain start launches a profile; position mode ends it by itself
            startPulse <= (pendTcw_r[`TFL_TCW_SMOOTH:`TFL_TCW_OFF] == 3'b000);
            moving_r <= (pendTcw_r[`TFL_TCW_SMOOTH:`TFL_TCW_OFF] == 3'b000);
         end
      end
   end

   // ----------------------------------------
   // motor drive output
   // ----------------------------------------
   // half-scale offset-binary code gives zero drive while the motor is off
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         driveOut <= `TFL_DRIVE_ZERO;
      end else begin
         driveOut <= motorOff ? `TFL_DRIVE_ZERO : pidDrive;
      end
   end
endmodule // tfl_trajectory_filter_loader

//--- rtl/tfl_consts.vh
`ifndef TFL_CONSTS_VH
`define TFL_CONSTS_VH
// ----------------------------------------
// command codes
// ----------------------------------------
`define TFL_CMD_START 8'h01
`define TFL_CMD_UPDFILT 8'h04
`define TFL_CMD_LOADFILT 8'h1E
`define TFL_CMD_LOADTRAJ 8'h1F
// ----------------------------------------
// apb byte offsets
// ----------------------------------------
`define TFL_OFF_CMD 8'h00
`define TFL_OFF_DATA 8'h04
`define TFL_OFF_STATUS 8'h08
`define TFL_OFF_ACC 8'h0C
`define TFL_OFF_VEL 8'h10
`define TFL_OFF_POS 8'h14
`define TFL_OFF_GAINA 8'h18
`define TFL_OFF_GAINB 8'h1C
`define TFL_OFF_FILTCTL 8'h20
// ----------------------------------------
// trajectory control word bit positions
// ----------------------------------------
`define TFL_TCW_FWD 12
`define TFL_TCW_VEL 11
`define TFL_TCW_SMOOTH 10
`define TFL_TCW_ABRUPT 9
`define TFL_TCW_OFF 8
`define TFL_TCW_ACC_LD 5
`define TFL_TCW_ACC_REL 4
`define TFL_TCW_VEL_LD 3
`define TFL_TCW_VEL_REL 2
`define TFL_TCW_POS_LD 1
`define TFL_TCW_POS_REL 0
// ----------------------------------------
// filter control word fields
// ----------------------------------------
`define TFL_FCW_IVL_HI 15
`define TFL_FCW_IVL_LO 8
`define TFL_FCW_FLG_HI 3
// ----------------------------------------
// status register bit positions
// ----------------------------------------
`define TFL_ST_BUSY 0
`define TFL_ST_CMDERR 1
`define TFL_ST_TDONE 2
`define TFL_ST_MOFF 7
`define TFL_ST_ACCLD 8
`define TFL_ST_UDFP 9
`define TFL_ST_FWD 10
`define TFL_ST_VEL 11
`define TFL_ST_MOVING 12
// ----------------------------------------
// timing counts and reset values
// ----------------------------------------
`define TFL_SAMPLE_CLKS 2048
`define TFL_BUSY_CYCLES 4'h4
`define TFL_DRIVE_ZERO 12'h800
`define TFL_RST_MOFF 1'b1
`define TFL_RST_WORD32 32'h00000000
`define TFL_RST_WORD16 16'h0000
`endif

//--- rtl/tfl_sample_timer.v
`timescale 1ns/10ps
`include "tfl_consts.vh"
module tfl_sample_timer #(
   parameter SAMPLE_CLKS = `TFL_SAMPLE_CLKS
) (
   input wire clk,
   input wire nrst,
   input wire [7:0] derivCode,
   output reg sampleTick,
   output reg derivTick
);
   reg [11:0] clkCnt_r;
   reg [7:0] smpCnt_r;
   localparam [11:0] LAST_CLK = SAMPLE_CLKS[11:0] - 12'h001;

   // ----------------------------------------
   // sample boundary and derivative interval
   // ----------------------------------------
   // derivative interval is (code+1) samples, i.e. (code+1)*2048 clocks
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         clkCnt_r <= 12'h000;
         smpCnt_r <= 8'h00;
         sampleTick <= 1'b0;
         derivTick <= 1'b0;
      end else begin
         sampleTick <= (clkCnt_r == LAST_CLK);
         derivTick <= 1'b0;
         if (clkCnt_r == LAST_CLK) begin
            clkCnt_r <= 12'h000;
            if (smpCnt_r >= derivCode) begin
               smpCnt_r <= 8'h00;
               derivTick <= 1'b1;
            end else begin
               smpCnt_r <= smpCnt_r + 8'h01;
            end
         end else begin
            clkCnt_r <= clkCnt_r + 12'h001;
         end
      end
   end
endmodule // tfl_sample_timer

//--- rtl/tfl_word_asm.v
`timescale 1ns/10ps
module tfl_word_asm (
   input wire clk,
   input wire nrst,
   input wire clear,
   input wire byteStb,
   input wire [7:0] byteIn,
   output reg wordStb,
   output reg [15:0] wordOut
);
   reg half_r;
   reg [7:0] hiByte_r;

   // ----------------------------------------
   // pair bytes, more significant first
   // ----------------------------------------
   // a new command drops any half word so a lost byte cannot skew later words
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         half_r <= 1'b0;
         hiByte_r <= 8'h00;
         wordStb <= 1'b0;
         wordOut <= 16'h0000;
      end else begin
         wordStb <= 1'b0;
         if (clear) begin
            half_r <= 1'b0;
         end else if (byteStb) begin
            if (!half_r) begin
               hiByte_r <= byteIn;
               half_r <= 1'b1;
            end else begin
               wordOut <= {hiByte_r, byteIn};
               wordStb <= 1'b1;
               half_r <= 1'b0;
            end
         end
      end
   end
endmodule // tfl_word_asm

//--- testbench/tfl_loader_props.sv
`timescale 1ns/10ps
module tfl_loader_props #(
   parameter SAMPLE_CLKS = 2048,
   parameter DRIVE_W = 12
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [DRIVE_W-1:0] pidDrive,
   input wire logic [DRIVE_W-1:0] driveOut,
   input wire logic motorOff,
   input wire logic startPulse,
   input wire logic smoothStop,
   input wire logic [31:0] workAccel,
   input wire logic [31:0] workVel,
   input wire logic [15:0] proportionalGain,
   input wire logic sampleTick,
   input wire logic derivTick
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   logic [15:0] tickGap_r;
   logic seenTick_r;
   // ----------------------------------------
   // tick spacing counter
   // ----------------------------------------
   // the first tick after reset has no reference, so it is not judged
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tickGap_r <= 16'h0000;
         seenTick_r <= 1'b0;
      end else if (sampleTick) begin
         tickGap_r <= 16'h0000;
         seenTick_r <= 1'b1;
      end else begin
         tickGap_r <= tickGap_r + 16'h0001;
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   chk_tick_period: assert property (sampleTick && seenTick_r |-> tickGap_r == SAMPLE_CLKS - 1)
      else $error("sample tick spacing wrong");
   chk_deriv_aligned: assert property (derivTick |-> sampleTick)
      else $error("derivative tick off a sample boundary");
   chk_drive_off: assert property (motorOff && $past(motorOff) |-> driveOut == 12'h800)
      else $error("drive not at zero code while motor off");
   chk_drive_pass: assert property (!motorOff && !$past(motorOff) |-> driveOut == $past(pidDrive))
      else $error("drive does not follow filter output");
   chk_start_tick: assert property (startPulse |-> sampleTick || $past(sampleTick))
      else $error("start applied off a sample boundary");
   chk_start_pulse: assert property (startPulse |=> !startPulse)
      else $error("start pulse longer than one cycle");
   chk_stop_excl: assert property (smoothStop |-> !startPulse)
      else $error("smooth stop together with plain start");
   chk_work_sync: assert property ($changed(workVel) || $changed(workAccel) |-> sampleTick || $past(sampleTick))
      else $error("working trajectory changed off a boundary");
   chk_gain_sync: assert property ($changed(proportionalGain) |-> sampleTick || $past(sampleTick))
      else $error("gain changed off a sample boundary");
   chk_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("bus answer not in the access cycle");
   cover property (startPulse);
   cover property (smoothStop);
   cover property (derivTick);
   cover property (pready && pslverr);
endmodule // tfl_loader_props

bind tfl_trajectory_filter_loader tfl_loader_props #(.SAMPLE_CLKS(SAMPLE_CLKS), .DRIVE_W(DRIVE_W)) i_props (
   .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
   .pidDrive(pidDrive), .driveOut(driveOut), .motorOff(motorOff), .startPulse(startPulse),
   .smoothStop(smoothStop), .workAccel(workAccel), .workVel(workVel),
   .proportionalGain(proportionalGain), .sampleTick(sampleTick), .derivTick(derivTick));

//--- testbench/tfl_host_model.sv
`timescale 1ns/10ps
`include "tfl_consts.vh"
module tfl_host_model (
   input wire logic clk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   logic hung;
   // bus idle until the bench asks for a transfer
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      hung = 1'b0;
   end
   // setup cycle, then access held until pready is seen at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
      output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      hung = hung | (n >= 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
      xfer(1'b0, a, 32'h00000000, q, e);
   endtask
   // poll busy first; a write while busy would be lost without notice
   task automatic idle;
      logic [31:0] q;
      logic e;
      int n;
      n = 0;
      do begin
         rd(`TFL_OFF_STATUS, q, e);
         n++;
      end while (q[`TFL_ST_BUSY] !== 1'b0 && n < 40);
      hung = hung | (n >= 40);
   endtask
   task automatic cmd(input logic [7:0] c);
      idle;
      wr(`TFL_OFF_CMD, {24'h000000, c});
   endtask
   // more significant byte first, busy polled before every byte
   task automatic word(input logic [15:0] w);
      idle;
      wr(`TFL_OFF_DATA, {24'h000000, w[15:8]});
      idle;
      wr(`TFL_OFF_DATA, {24'h000000, w[7:0]});
   endtask
   task automatic p32(input logic [31:0] v);
      word(v[31:16]);
      word(v[15:0]);
   endtask
endmodule // tfl_host_model

//--- testbench/tfl_trajectory_filter_loader_test.sv
`timescale 1ns/10ps
`include "tfl_consts.vh"
module tfl_trajectory_filter_loader_test;
   localparam int SCLK = 16;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, trajDone, e;
   logic velMode, fwdDir, motorOff, startPulse, smoothStop, sampleTick, derivTick;
   logic [7:0] paddr, derivCode;
   logic [11:0] pidDrive, driveOut;
   logic [15:0] proportionalGain, integralGain, derivativeGain, integrationLimit;
   logic [31:0] pwdata, prdata, actualPos, workAccel, workVel, workTarget, q, tPos;
   int badCount = 0;
   int numChecks = 0;
   int nStart = 0;
   int nSmooth = 0;
   int cyc = 0;
   int lastD = 0;
   int gap = 0;
   tfl_trajectory_filter_loader #(.SAMPLE_CLKS(SCLK), .DRIVE_W(12)) i_dut (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .trajDone(trajDone),
      .actualPos(actualPos), .pidDrive(pidDrive), .driveOut(driveOut), .workAccel(workAccel),
      .workVel(workVel), .workTarget(workTarget), .velMode(velMode), .fwdDir(fwdDir),
      .motorOff(motorOff), .startPulse(startPulse), .smoothStop(smoothStop),
      .proportionalGain(proportionalGain), .integralGain(integralGain), .derivativeGain(derivativeGain),
      .integrationLimit(integrationLimit), .derivCode(derivCode), .sampleTick(sampleTick),
      .derivTick(derivTick));
   tfl_host_model h (
      .clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   // ----------------------------------------
   // clock, filter output stimulus and pulse monitors
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // a moving filter output makes a stuck drive path visible
   always @(posedge clk) begin
      cyc++;
      pidDrive <= pidDrive + 12'h001;
      actualPos <= actualPos + 32'h00000001;
      if (sampleTick === 1'b1) tPos = actualPos;
      if (startPulse === 1'b1) nStart++;
      if (smoothStop === 1'b1) nSmooth++;
      if (derivTick === 1'b1) begin
         gap = cyc - lastD;
         lastD = cyc;
      end
      if (h.hung === 1'b1) waitOut;
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      numChecks++;
      if (g !== x) begin
         badCount++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task automatic stopTest;
      $display("checks %0d mismatches %0d", numChecks, badCount);
      if (badCount == 0 && numChecks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic waitOut;
      badCount++;
      stopTest;
   endtask
   task automatic traj(input logic [15:0] w);
      h.cmd(`TFL_CMD_LOADTRAJ);
      h.word(w);
   endtask
   task automatic go;
      h.cmd(`TFL_CMD_START);
      h.idle;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic doReset;
      cmp({20'h00000, driveOut}, 32'h00000800);
      h.rd(`TFL_OFF_STATUS, q, e);
      cmp(q & 32'h00001FFF, 32'h00000084);
      h.rd(8'h40, q, e);
      cmp({31'h00000000, e}, 32'h00000001);
   endtask
   // unused bits and direction set in position mode must have no effect
   task automatic doLoad;
      traj(16'hF0EA);
      h.p32(32'h00010000);
      h.p32(32'h00050000);
      h.p32(32'h3FFFFFFF);
      cmp(workVel, 32'h00000000);
      go;
      cmp(32'(nStart), 32'h00000001);
      cmp(workAccel, 32'h00010000);
      cmp(workVel, 32'h00050000);
      cmp(workTarget, 32'h3FFFFFFF);
      cmp({29'h00000000, velMode, fwdDir, motorOff}, 32'h00000000);
   endtask
   task automatic doRel;
      traj(16'h180F);
      h.p32(32'h00010000);
      h.p32(32'hFFFFFFFF);
      go;
      cmp(workVel, 32'h00060000);
      cmp(workTarget, 32'h3FFFFFFE);
      cmp(workAccel, 32'h00010000);
      cmp({30'h00000000, velMode, fwdDir}, 32'h00000003);
   endtask
   // acceleration changed in mid move: the start is refused
   task automatic doErr;
      int s;
      traj(16'h0020);
      h.p32(32'h00002000);
      s = nStart;
      go;
      h.rd(`TFL_OFF_STATUS, q, e);
      cmp({31'h00000000, q[`TFL_ST_CMDERR]}, 32'h00000001);
      cmp(32'(nStart - s), 32'h00000000);
      cmp(workAccel, 32'h00010000);
      h.wr(`TFL_OFF_STATUS, 32'h00000002);
   endtask
   task automatic doStops;
      int s;
      trajDone <= 1'b1;
      traj(16'h0200);
      go;
      cmp(workTarget, tPos);
      s = nSmooth;
      traj(16'h0400);
      go;
      cmp(32'(nSmooth - s), 32'h00000001);
      traj(16'h0100);
      go;
      cmp({31'h00000000, motorOff}, 32'h00000001);
      cmp({20'h00000, driveOut}, 32'h00000800);
   endtask
   task automatic doFilter;
      int n;
      h.cmd(`TFL_CMD_LOADFILT);
      h.word(16'h020F);
      h.word(16'h1111);
      h.word(16'h2222);
      h.word(16'h3333);
      h.word(16'h4444);
      cmp({16'h0000, proportionalGain}, 32'h00000000);
      h.cmd(`TFL_CMD_UPDFILT);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sampleTick !== 1'b1 && n < 40);
      if (n >= 40) waitOut;
      repeat (2) @(posedge clk);
      cmp({proportionalGain, integralGain}, 32'h11112222);
      cmp({derivativeGain, integrationLimit}, 32'h33334444);
      cmp({24'h000000, derivCode}, 32'h00000002);
      repeat (8 * SCLK) @(posedge clk);
      cmp(32'(gap), 32'(3 * SCLK));
   endtask
   // a byte written while busy must vanish, else the words shift
   task automatic doBusy;
      h.cmd(`TFL_CMD_LOADTRAJ);
      h.wr(`TFL_OFF_DATA, 32'h000000FF);
      h.word(16'h0008);
      h.p32(32'h00030000);
      go;
      cmp(workVel, 32'h00030000);
      h.rd(`TFL_OFF_STATUS, q, e);
      cmp({31'h00000000, q[`TFL_ST_CMDERR]}, 32'h00000000);
      cmp({31'h00000000, motorOff}, 32'h00000000);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      trajDone = 1'b0;
      actualPos = 32'h00000000;
      pidDrive = 12'h000;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      doReset;
      doLoad;
      doRel;
      doErr;
      doStops;
      doFilter;
      doBusy;
      stopTest;
   end
endmodule // tfl_trajectory_filter_loader_test
